/* hdl/homing_pkg.sv */
// package of constants and types for the homing sequencer
// Behaviour
// - launch codes one to six start homing
// - index codes only with index pulse fitted
// - preset redefines position only at standstill
// - search speed default 60 toward switch
// - retract speed default 6 off switch
// - edge search beyond max distance errors
// - offset travel then take reference point
// - switch directions: bit0 withdraw, bit1 offset
// - index bit0 stored and readable only, index codes stop at the edge with no retract
// - origin value loaded at reference point
// - sixteen bit fault cause readable
// - mode state bit5 on success
// - end on target, error or quick stop
// - interrupted homing gives no valid zero
// - refuse mode change while homing runs
// - parameter writes act immediately, speeds taken only at launch and switch hit
// - index search one revolution, stop at edge
`default_nettype none
package homing_pkg;
  // parameter indices within the homing group
  localparam logic [7:0] IDX_LAUNCH = 8'h01;
  localparam logic [7:0] IDX_PROGRESS = 8'h02;
  localparam logic [7:0] IDX_PRESET = 8'h03;
  localparam logic [7:0] IDX_SEARCH_SPD = 8'h04;
  localparam logic [7:0] IDX_RETRACT_SPD = 8'h05;
  localparam logic [7:0] IDX_MAX_SEARCH = 8'h06;
  localparam logic [7:0] IDX_OFFSET = 8'h07;
  localparam logic [7:0] IDX_SW_DIRS = 8'h09;
  localparam logic [7:0] IDX_INDEX_DIR = 8'h0a;
  localparam logic [7:0] IDX_ORIGIN = 8'h0b;
  localparam logic [7:0] IDX_FAULT = 8'h0d;
  // reset values
  localparam logic [15:0] RST_SEARCH_SPD = 16'h003c;
  localparam logic [15:0] RST_RETRACT_SPD = 16'h0006;
  localparam logic [31:0] RST_MAX_SEARCH = 32'h00030d40;
  localparam logic [31:0] RST_OFFSET = 32'h000000c8;
  localparam logic [15:0] RST_DIRS = 16'h0000;
  localparam logic [31:0] RST_ORIGIN = 32'h00000000;
  // progress word bit positions
  localparam int PRG_FAIL = 15;
  localparam int PRG_DONE = 14;
  localparam int PRG_SOFT = 7;
  localparam int PRG_HOME = 3;
  localparam int PRG_HARD = 2;
  localparam int PRG_NEG = 1;
  localparam int PRG_POS = 0;
  localparam int MODE_REF_OK = 5;
  // command word value for quick stop
  localparam logic [15:0] CMD_QUICK_STOP = 16'h0004;
  // fault cause codes
  localparam logic [15:0] FC_NONE = 16'h0000;
  localparam logic [15:0] FC_BAD_CODE = 16'h0001;
  localparam logic [15:0] FC_NO_EDGE = 16'h0002;
  localparam logic [15:0] FC_WRONG_LIMIT = 16'h0003;
  localparam logic [15:0] FC_HARD_HALT = 16'h0004;
  localparam logic [15:0] FC_SOFT_HALT = 16'h0005;
  localparam logic [15:0] FC_NO_INDEX = 16'h0006;
  // sequencer states, gray from idle through settle, two bits change on the return to idle
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEARCH = 3'b001,
    ST_EDGE = 3'b011,
    ST_OFFSET = 3'b010,
    ST_SETTLE = 3'b110
  } homing_state_e;
endpackage : homing_pkg
`default_nettype wire

/* hdl/homing_param_bank.sv */
// writable homing parameter bank
`default_nettype none
module homing_param_bank
  import homing_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_index_in,
  input wire logic [31:0] wr_data_in,
  output logic [15:0] search_speed_out,
  output logic [15:0] retract_speed_out,
  output logic [31:0] max_search_out,
  output logic [31:0] offset_out,
  output logic [1:0] sw_dirs_out,
  output logic index_dir_out,
  output logic [31:0] origin_out
);
  // all parameters in one struct
  typedef struct packed {
    logic [15:0] srch;
    logic [15:0] retr;
    logic [31:0] maxs;
    logic [31:0] offs;
    logic [1:0] dirs;
    logic idir;
    logic [31:0] orig;
  } bank_s;
  bank_s q, d;

  // writes land at once, no commit step
  always_comb
  begin
    d = q;
    if (wr_en_in)
    begin
      unique case (wr_index_in)
        IDX_SEARCH_SPD: d.srch = wr_data_in[15:0];
        IDX_RETRACT_SPD: d.retr = wr_data_in[15:0];
        IDX_MAX_SEARCH: d.maxs = wr_data_in;
        IDX_OFFSET: d.offs = wr_data_in;
        IDX_SW_DIRS: d.dirs = wr_data_in[1:0];
        IDX_INDEX_DIR: d.idir = wr_data_in[0];
        IDX_ORIGIN: d.orig = wr_data_in;
        default: d = q;
      endcase
    end
  end

  // register with documented defaults
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      q <= '{RST_SEARCH_SPD, RST_RETRACT_SPD, RST_MAX_SEARCH, RST_OFFSET,
             RST_DIRS[1:0], RST_DIRS[0], RST_ORIGIN};
    end
    else
    begin
      q <= d;
    end
  end

  assign search_speed_out = q.srch;
  assign retract_speed_out = q.retr;
  assign max_search_out = q.maxs;
  assign offset_out = q.offs;
  assign sw_dirs_out = q.dirs;
  assign index_dir_out = q.idir;
  assign origin_out = q.orig;
endmodule : homing_param_bank
`default_nettype wire

/* hdl/homing_step_counter.sv */
// up-only step distance counter for homing phases, saturating at 32'h7fff_ffff
`default_nettype none
module homing_step_counter
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  input wire logic step_in,
  output logic [31:0] count_out
);
  typedef struct packed {
    logic [31:0] cnt;
  } cnt_s;
  cnt_s q, d;

  // clear has priority, else count steps
  always_comb
  begin
    d = q;
    if (clear_in)
    begin
      d.cnt = 32'h0000_0000;
    end
    else if (step_in && q.cnt != 32'h7fff_ffff)
    begin
      d.cnt = q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign count_out = q.cnt;
endmodule : homing_step_counter
`default_nettype wire

/* hdl/drive_homing_sequencer.sv */
// homing sequencer top: parameter access, sequence control, status
`default_nettype none
module drive_homing_sequencer
  import homing_pkg::*;
#(
  parameter bit INDEX_FITTED = 1'b1,
  parameter int unsigned STEPS_PER_REV = 20000
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  // parameter write port from the fieldbus side
  input wire logic wr_en_in,
  input wire logic [7:0] wr_index_in,
  input wire logic [31:0] wr_data_in,
  // parameter read port, data valid next cycle
  input wire logic [7:0] rd_index_in,
  output logic [31:0] rd_data_out,
  // drive command word write
  input wire logic cmd_wr_in,
  input wire logic [15:0] drive_command_word_in,
  // request to change operating mode
  input wire logic mode_change_req_in,
  output logic mode_change_ack_out,
  // switch and halt inputs, active high when tripped
  input wire logic neg_limit_switch_in,
  input wire logic pos_limit_switch_in,
  input wire logic home_switch_in,
  input wire logic index_pulse_in,
  input wire logic soft_halt_fault_in,
  input wire logic hard_halt_fault_in,
  // motion interface to the step generator
  input wire logic standstill_in,
  input wire logic step_done_in,
  output logic move_en_out,
  output logic move_neg_dir_out,
  output logic [15:0] move_speed_out,
  output logic stop_out,
  output logic pos_load_out,
  output logic [31:0] pos_load_value_out,
  // status
  output logic [15:0] homing_progress_word_out,
  output logic [15:0] homing_fault_cause_out,
  output logic [15:0] mode_state_word_out,
  output logic busy_out
);
  import homing_pkg::*;

  // bank outputs and step counter signals
  logic [15:0] search_speed;
  logic [15:0] retract_speed;
  logic [31:0] max_search;
  logic [31:0] offset_dist;
  logic [1:0] sw_dirs;
  logic index_dir;
  logic [31:0] origin_pos;
  logic [31:0] dist_count;
  logic count_clear;

  // all sequencer state in one struct
  typedef struct packed {
    homing_state_e st;
    logic [2:0] code;       // active launch code
    logic neg;              // current travel direction negative
    logic [15:0] spd;       // current speed
    logic running;          // move enable
    logic stop;             // stop request
    logic load;             // position load pulse
    logic [31:0] load_val;  // value to load
    logic [15:0] progress;  // progress word
    logic [15:0] fault;     // fault cause
    logic ref_ok;           // mode state bit 5
    logic [31:0] preset;    // last preset value
    logic [31:0] rd;        // read data
  } seq_s;
  seq_s q, d;

  homing_param_bank u_bank (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(wr_en_in),
    .wr_index_in(wr_index_in),
    .wr_data_in(wr_data_in),
    .search_speed_out(search_speed),
    .retract_speed_out(retract_speed),
    .max_search_out(max_search),
    .offset_out(offset_dist),
    .sw_dirs_out(sw_dirs),
    .index_dir_out(index_dir),
    .origin_out(origin_pos)
  );

  homing_step_counter u_count (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clear_in(count_clear),
    .step_in(step_done_in),
    .count_out(dist_count)
  );

  // launch code legal check, index codes need index fitted
  function automatic logic code_ok(input logic [15:0] c);
    code_ok = (c >= 16'h0001 && c <= 16'h0004) ||
              (INDEX_FITTED && (c == 16'h0005 || c == 16'h0006));
  endfunction

  // sensed level of the switch targeted by a code
  function automatic logic target_hit(input logic [2:0] c, input logic nl,
                                      input logic pl, input logic hs, input logic ix);
    unique case (c)
      3'd1: target_hit = pl;
      3'd2: target_hit = nl;
      3'd3, 3'd4: target_hit = hs;
      default: target_hit = ix;
    endcase
  endfunction

  // helpers
  logic launch_wr;
  logic preset_wr;
  logic quick_stop;
  logic hit;
  logic is_index;
  logic [31:0] rev_steps;
  assign launch_wr = wr_en_in && wr_index_in == IDX_LAUNCH;
  assign preset_wr = wr_en_in && wr_index_in == IDX_PRESET;
  assign quick_stop = cmd_wr_in && drive_command_word_in == CMD_QUICK_STOP;
  assign hit = target_hit(q.code, neg_limit_switch_in, pos_limit_switch_in,
                          home_switch_in, index_pulse_in);
  assign is_index = q.code == 3'd5 || q.code == 3'd6;
  assign rev_steps = 32'(STEPS_PER_REV);
  assign count_clear = (q.st == ST_IDLE) || (d.st != q.st);

  // sequencer next state
  always_comb
  begin
    logic fail;
    logic [15:0] fcode;
    logic [15:0] ebits;
    fail = 1'b0;
    fcode = FC_NONE;
    ebits = 16'h0000;
    d = q;
    d.load = 1'b0;
    d.stop = 1'b0;
    unique case (q.st)
      ST_IDLE:
      begin
        if (launch_wr)
        begin
          if (code_ok(wr_data_in[15:0]))
          begin
            d.code = wr_data_in[2:0];
            d.ref_ok = 1'b0;
            d.progress = 16'h0000;
            d.fault = FC_NONE;
            d.running = 1'b1;
            // codes 2,3,5 negative search, codes 1,4,6 positive
            d.neg = (wr_data_in[2:0] == 3'd2) || (wr_data_in[2:0] == 3'd3) ||
                    (wr_data_in[2:0] == 3'd5);
            d.spd = search_speed;
            d.st = ST_SEARCH;
          end
          else
          begin
            d.progress = 16'h0000;
            d.progress[PRG_FAIL] = 1'b1;
            d.progress[PRG_DONE] = 1'b1;
            d.fault = FC_BAD_CODE;
          end
        end
        else if (preset_wr && standstill_in)
        begin
          d.preset = wr_data_in;
          d.load = 1'b1;
          d.load_val = wr_data_in;
          d.progress = 16'h0000;
          d.progress[PRG_DONE] = 1'b1;
        end
      end
      ST_SEARCH:
      begin
        if (hit)
        begin
          // leave switch at retract speed
          d.spd = retract_speed;
          if (is_index)
          begin
            // index edge reached: stop here exactly
            d.running = 1'b0;
            d.stop = 1'b1;
            d.st = ST_SETTLE;
          end
          else
          begin
            d.neg = (q.code == 3'd3 || q.code == 3'd4) ? sw_dirs[0] :
                    (q.code == 3'd2) ? 1'b0 : 1'b1;
            d.st = ST_EDGE;
          end
        end
        else if (is_index && dist_count >= rev_steps)
        begin
          fail = 1'b1;
          fcode = FC_NO_INDEX;
        end
      end
      ST_EDGE:
      begin
        if (!hit)
        begin
          d.neg = (q.code == 3'd3 || q.code == 3'd4) ? sw_dirs[1] : q.neg;
          d.st = ST_OFFSET;
        end
        else if (dist_count >= max_search)
        begin
          fail = 1'b1;
          fcode = FC_NO_EDGE;
        end
      end
      ST_OFFSET:
      begin
        if (dist_count >= offset_dist)
        begin
          d.running = 1'b0;
          d.stop = 1'b1;
          d.st = ST_SETTLE;
        end
      end
      ST_SETTLE:
      begin
        if (standstill_in)
        begin
          // once standstill is shown, load origin, flag reference and show done
          d.load = 1'b1;
          d.load_val = origin_pos;
          d.ref_ok = 1'b1;
          d.progress[PRG_DONE] = 1'b1;
          d.st = ST_IDLE;
        end
      end
      default:
      begin
        d.st = ST_IDLE;
        d.running = 1'b0;
      end
    endcase
    // unexpected switch or halt while moving ends with failure
    if (q.st != ST_IDLE && q.st != ST_SETTLE)
    begin
      if (hard_halt_fault_in)
      begin
        fail = 1'b1;
        fcode = FC_HARD_HALT;
        ebits[PRG_HARD] = 1'b1;
      end
      else if (soft_halt_fault_in || quick_stop)
      begin
        fail = 1'b1;
        fcode = FC_SOFT_HALT;
        ebits[PRG_SOFT] = 1'b1;
      end
      else if (neg_limit_switch_in && q.code != 3'd2)
      begin
        fail = 1'b1;
        fcode = FC_WRONG_LIMIT;
        ebits[PRG_NEG] = 1'b1;
      end
      else if (pos_limit_switch_in && q.code != 3'd1)
      begin
        fail = 1'b1;
        fcode = FC_WRONG_LIMIT;
        ebits[PRG_POS] = 1'b1;
      end
      else if (fail && (q.code == 3'd3 || q.code == 3'd4))
      begin
        ebits[PRG_HOME] = 1'b1;
      end
    end
    // quick stop while settling still interrupts the sequence
    else if (q.st == ST_SETTLE && quick_stop)
    begin
      fail = 1'b1;
      fcode = FC_SOFT_HALT;
      ebits[PRG_SOFT] = 1'b1;
    end
    // failure: all status fields at once, no valid zero
    if (fail)
    begin
      d.progress = ebits;
      d.progress[PRG_FAIL] = 1'b1;
      d.progress[PRG_DONE] = 1'b1;
      d.fault = fcode;
      d.ref_ok = 1'b0;
      d.running = 1'b0;
      d.stop = 1'b1;
      d.load = 1'b0;
      d.st = ST_IDLE;
    end
    // read data multiplexer
    unique case (rd_index_in)
      IDX_PROGRESS: d.rd = {16'h0000, q.progress};
      IDX_PRESET: d.rd = q.preset;
      IDX_SEARCH_SPD: d.rd = {16'h0000, search_speed};
      IDX_RETRACT_SPD: d.rd = {16'h0000, retract_speed};
      IDX_MAX_SEARCH: d.rd = max_search;
      IDX_OFFSET: d.rd = offset_dist;
      IDX_SW_DIRS: d.rd = {30'h0, sw_dirs};
      IDX_INDEX_DIR: d.rd = {31'h0, index_dir};
      IDX_ORIGIN: d.rd = origin_pos;
      IDX_FAULT: d.rd = {16'h0000, q.fault};
      IDX_LAUNCH: d.rd = {29'h0, q.code};
      default: d.rd = 32'h0000_0000;
    endcase
  end

  // one register for all state
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      q <= '{ST_IDLE, 3'h0, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 32'h0,
             16'h0000, FC_NONE, 1'b0, 32'h0, 32'h0};
    end
    else
    begin
      q <= d;
    end
  end

  // mode change refused while a sequence runs
  assign mode_change_ack_out = mode_change_req_in && q.st == ST_IDLE;
  assign busy_out = q.st != ST_IDLE;
  assign move_en_out = q.running;
  assign move_neg_dir_out = q.neg;
  assign move_speed_out = q.spd;
  assign stop_out = q.stop;
  assign pos_load_out = q.load;
  assign pos_load_value_out = q.load_val;
  assign homing_progress_word_out = q.progress;
  assign homing_fault_cause_out = q.fault;
  assign mode_state_word_out = {10'h000, q.ref_ok, 5'h00};
  assign rd_data_out = q.rd;
endmodule : drive_homing_sequencer
`default_nettype wire

/* bench/homing_checker_sva.sv */
// port assertions for the homing sequencer
`default_nettype none
module homing_checker
  import homing_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_index_in,
  input wire logic [31:0] wr_data_in,
  input wire logic cmd_wr_in,
  input wire logic [15:0] drive_command_word_in,
  input wire logic mode_change_req_in,
  input wire logic mode_change_ack_out,
  input wire logic standstill_in,
  input wire logic move_en_out,
  input wire logic stop_out,
  input wire logic pos_load_out,
  input wire logic [31:0] pos_load_value_out,
  input wire logic [15:0] homing_progress_word_out,
  input wire logic [15:0] homing_fault_cause_out,
  input wire logic [15:0] mode_state_word_out,
  input wire logic busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  logic launch_wr; // launch write while idle
  logic preset_wr; // preset write while idle
  logic [15:0] code; // launch code in the low half
  assign code = wr_data_in[15:0];
  assign launch_wr = wr_en_in && (wr_index_in == IDX_LAUNCH) && !busy_out;
  assign preset_wr = wr_en_in && (wr_index_in == IDX_PRESET) && !busy_out;
  property p_ack;
    mode_change_ack_out == (mode_change_req_in && !busy_out);
  endproperty
  a_ack: assert property (p_ack) else $error("mode ack wrong");
  property p_launch;
    launch_wr && code >= 16'h0001 && code <= 16'h0006 |=> busy_out && move_en_out;
  endproperty
  a_launch: assert property (p_launch) else $error("launch not started");
  property p_bad;
    launch_wr && (code == 16'h0000 || code > 16'h0006) |=> !busy_out
      && homing_progress_word_out[PRG_FAIL] && homing_fault_cause_out == FC_BAD_CODE;
  endproperty
  a_bad: assert property (p_bad) else $error("bad code accepted");
  property p_preset;
    preset_wr && standstill_in |=> pos_load_out && pos_load_value_out == $past(wr_data_in);
  endproperty
  a_preset: assert property (p_preset) else $error("preset not loaded");
  property p_preset_no;
    preset_wr && !standstill_in |=> !pos_load_out;
  endproperty
  a_preset_no: assert property (p_preset_no) else $error("preset while moving");
  property p_qstop;
    busy_out && cmd_wr_in && drive_command_word_in == CMD_QUICK_STOP |=> !busy_out
      && stop_out && homing_progress_word_out[PRG_SOFT] && homing_fault_cause_out == FC_SOFT_HALT;
  endproperty
  a_qstop: assert property (p_qstop) else $error("quick stop ignored");
  property p_fail;
    $rose(homing_progress_word_out[PRG_FAIL]) |-> homing_progress_word_out[PRG_DONE]
      && homing_fault_cause_out != FC_NONE && !busy_out;
  endproperty
  a_fail: assert property (p_fail) else $error("failure fields apart");
  property p_ref_ok;
    $rose(mode_state_word_out[MODE_REF_OK]) |-> homing_progress_word_out[PRG_DONE]
      && !homing_progress_word_out[PRG_FAIL];
  endproperty
  a_ref_ok: assert property (p_ref_ok) else $error("ref ok without success");
  c_launch: cover property (launch_wr ##1 busy_out);
  c_preset: cover property (preset_wr ##1 pos_load_out);
  c_ref_ok: cover property ($rose(mode_state_word_out[MODE_REF_OK]));
endmodule // homing_checker
bind drive_homing_sequencer homing_checker u_chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .wr_en_in(wr_en_in), .wr_index_in(wr_index_in), .wr_data_in(wr_data_in),
  .cmd_wr_in(cmd_wr_in), .drive_command_word_in(drive_command_word_in),
  .mode_change_req_in(mode_change_req_in), .mode_change_ack_out(mode_change_ack_out),
  .standstill_in(standstill_in), .move_en_out(move_en_out), .stop_out(stop_out),
  .pos_load_out(pos_load_out), .pos_load_value_out(pos_load_value_out),
  .homing_progress_word_out(homing_progress_word_out),
  .homing_fault_cause_out(homing_fault_cause_out),
  .mode_state_word_out(mode_state_word_out), .busy_out(busy_out));
`default_nettype wire

/* bench/motion_model.sv */
// step generator and axis switch model
`default_nettype none
module motion_model
#(
  parameter int LIMIT = 40,
  parameter int START = 10
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic move_en_in,
  input wire logic move_neg_dir_in,
  output logic standstill_out,
  output logic step_done_out,
  output logic neg_limit_switch_out,
  output logic pos_limit_switch_out,
  output logic home_switch_out,
  output logic index_pulse_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos; // axis position in steps
  // one step per cycle while motion is enabled
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pos <= START;
      step_done_out <= 1'b0;
      standstill_out <= 1'b1;
    end
    else
    begin
      step_done_out <= move_en_in;
      standstill_out <= !move_en_in && !step_done_out;
      if (move_en_in)
        pos <= move_neg_dir_in ? pos - 1 : pos + 1;
    end
  end
  // limits beyond the range, home on the negative side
  assign neg_limit_switch_out = pos < -LIMIT;
  assign pos_limit_switch_out = pos > LIMIT;
  assign home_switch_out = pos < 0;
  assign index_pulse_out = pos[4:0] == 5'h00;
endmodule // motion_model
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for the homing sequencer
`default_nettype none
module testbench
  import homing_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, resetn_in, wr_en_in, cmd_wr_in, mode_change_req_in, hard_halt_fault_in;
  logic [7:0] wr_index_in, rd_index_in;
  logic [31:0] wr_data_in, rd_data_out, pos_load_value_out, last_load;
  logic [15:0] drive_command_word_in, move_speed_out, prog, fault, mode;
  logic mode_change_ack_out, nls, pls, hs, ix, stand, step, move_en_out, neg_dir_out;
  logic stop_out, pos_load_out, busy_out;
  int miscompares, comparisons;
  logic [5:0] neg_dir = 6'b010110; // search direction per launch code
  logic [7:0] d_idx [7] = '{IDX_SEARCH_SPD, IDX_RETRACT_SPD, IDX_MAX_SEARCH, IDX_OFFSET,
    IDX_SW_DIRS, IDX_INDEX_DIR, IDX_ORIGIN};
  logic [31:0] d_val [7] = '{{16'h0, RST_SEARCH_SPD}, {16'h0, RST_RETRACT_SPD},
    RST_MAX_SEARCH, RST_OFFSET, {16'h0, RST_DIRS}, {16'h0, RST_DIRS}, RST_ORIGIN};
  logic [31:0] bad [2] = '{32'h0, 32'h7};
  drive_homing_sequencer #(.INDEX_FITTED(1'b1), .STEPS_PER_REV(64)) u_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .wr_en_in(wr_en_in), .wr_index_in(wr_index_in),
    .wr_data_in(wr_data_in), .rd_index_in(rd_index_in), .rd_data_out(rd_data_out),
    .cmd_wr_in(cmd_wr_in), .drive_command_word_in(drive_command_word_in),
    .mode_change_req_in(mode_change_req_in), .mode_change_ack_out(mode_change_ack_out),
    .neg_limit_switch_in(nls), .pos_limit_switch_in(pls), .home_switch_in(hs),
    .index_pulse_in(ix), .hard_halt_fault_in(hard_halt_fault_in),
    .soft_halt_fault_in(1'b0),
    .standstill_in(stand), .step_done_in(step), .move_en_out(move_en_out),
    .move_neg_dir_out(neg_dir_out), .move_speed_out(move_speed_out), .stop_out(stop_out),
    .pos_load_out(pos_load_out), .pos_load_value_out(pos_load_value_out),
    .homing_progress_word_out(prog), .homing_fault_cause_out(fault),
    .mode_state_word_out(mode), .busy_out(busy_out));
  motion_model u_motion (.clk_in(clk_in), .resetn_in(resetn_in), .move_en_in(move_en_out),
    .move_neg_dir_in(neg_dir_out), .standstill_out(stand), .step_done_out(step),
    .neg_limit_switch_out(nls), .pos_limit_switch_out(pls), .home_switch_out(hs),
    .index_pulse_out(ix));
  // clock and position load capture
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in)
    if (pos_load_out === 1'b1)
      last_load <= pos_load_value_out;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // one-cycle parameter write strobe
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    @(posedge clk_in);
    wr_en_in <= 1'b1;
    wr_index_in <= i;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask
  task automatic rd_check(input logic [7:0] i, input logic [31:0] e);
    @(posedge clk_in);
    rd_index_in <= i;
    tick(2);
    check(rd_data_out, e);
  endtask
  task automatic qstop;
    @(posedge clk_in);
    cmd_wr_in <= 1'b1;
    drive_command_word_in <= CMD_QUICK_STOP;
    @(posedge clk_in);
    cmd_wr_in <= 1'b0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 4000)
    begin
      @(posedge clk_in);
      n++;
    end
    tick(4);
    check({31'h0, busy_out}, 32'h0);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog against a hung sequence
  initial
  begin
    #2000000;
    miscompares++;
    give_verdict();
  end
  // main test sequence
  initial
  begin
    {clk_in, resetn_in, wr_en_in, cmd_wr_in, mode_change_req_in, hard_halt_fault_in} = '0;
    {wr_index_in, rd_index_in, wr_data_in, drive_command_word_in, last_load} = '0;
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd_check(d_idx[i], d_val[i]);
    wr(IDX_OFFSET, 32'h14);
    wr(IDX_MAX_SEARCH, 32'h12c);
    wr(IDX_ORIGIN, 32'h1234);
    rd_check(IDX_ORIGIN, 32'h1234);
    rd_check(IDX_MAX_SEARCH, 32'h12c);
    $display("test parameters done");
    for (int c = 1; c <= 6; c++)
    begin
      wr(IDX_LAUNCH, 32'(c));
      #1;
      check({31'h0, busy_out}, 32'h1);
      check({31'h0, neg_dir_out}, {31'h0, neg_dir[c-1]});
      check({16'h0, move_speed_out}, {16'h0, RST_SEARCH_SPD});
      qstop();
      tick(1);
      check({16'h0, prog}, 32'hc080);
      check({16'h0, fault}, {16'h0, FC_SOFT_HALT});
      check({31'h0, mode[MODE_REF_OK]}, 32'h0);
    end
    foreach (bad[i])
    begin
      wr(IDX_LAUNCH, bad[i]);
      tick(1);
      check({16'h0, fault}, {16'h0, FC_BAD_CODE});
      check({16'h0, prog & 16'hc000}, 32'hc000);
    end
    $display("test launch codes done");
    wr(IDX_LAUNCH, 32'h2);
    mode_change_req_in <= 1'b1;
    tick(3);
    check({31'h0, mode_change_ack_out}, 32'h0);
    wait_idle();
    check({31'h0, mode_change_ack_out}, 32'h1);
    check({16'h0, prog & 16'hc000}, 32'h4000);
    check({31'h0, mode[MODE_REF_OK]}, 32'h1);
    check(last_load, 32'h1234);
    @(posedge clk_in);
    mode_change_req_in <= 1'b0;
    wr(IDX_PRESET, 32'hfffffc18);
    tick(2);
    check(last_load, 32'hfffffc18);
    rd_check(IDX_PRESET, 32'hfffffc18);
    $display("test full run and preset done");
    wr(IDX_LAUNCH, 32'h1);
    tick(3);
    wr(IDX_PRESET, 32'h55);
    @(posedge clk_in);
    hard_halt_fault_in <= 1'b1;
    tick(2);
    check({16'h0, fault}, {16'h0, FC_HARD_HALT});
    check({16'h0, prog & 16'hc004}, 32'hc004);
    check({31'h0, mode[MODE_REF_OK]}, 32'h0);
    check(last_load, 32'hfffffc18);
    rd_check(IDX_PROGRESS, 32'hc004);
    rd_check(IDX_FAULT, {16'h0, FC_HARD_HALT});
    @(posedge clk_in);
    hard_halt_fault_in <= 1'b0;
    $display("test hard halt done");
    wr(IDX_LAUNCH, 32'h6);
    tick(2);
    wait_idle();
    check({31'h0, mode[MODE_REF_OK]}, 32'h1);
    check(last_load, 32'h1234);
    $display("test index run done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
